/* cstp_point_table.sv */
// Cam switch point table with query/edit commands and crossing state update
`timescale 1ns/1ns
`default_nettype none
`include "cstp_regs.svh"

module cstp_point_table
  import cstp_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Spindle position samples from the motion core
  input  wire logic [31:0] spindle_pos,
  input  wire logic        spindle_stb,
  // Command status and point states
  output logic             cmd_busy,
  output logic             cmd_done,
  output logic             cmd_valid,
  output logic             cmd_error,
  output logic      [15:0] fault_code,
  output logic      [7:0]  point_state,
  // Interrupt
  output logic             irq
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic apply_action(input cstp_action_e act, input logic cur);
    logic res;
    res = cur;
    unique case (act)
      ACT_HOLD:   res = cur;
      ACT_SET:    res = 1'b1;
      ACT_CLEAR:  res = 1'b0;
      ACT_TOGGLE: res = ~cur;
    endcase
    return res;
  endfunction : apply_action

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : is_addr

  // ************************************************************
  // Storage
  // ************************************************************
  cstp_entry_s  table_ff [TBL_NUM][PNT_NUM];
  logic [7:0]   state_ff [TBL_NUM];
  logic [31:0]  cmd_reg_ff;
  logic [31:0]  edit_pos_ff;
  logic         exec_ff;
  cstp_cmd_s    cmd_ff;
  cstp_fsm_e    fsm_ff;
  logic         busy_ff;
  logic         done_ff;
  logic         valid_ff;
  logic         error_ff;
  logic [15:0]  code_ff;
  cstp_pos_t    qry_pos_ff;
  cstp_action_e qry_fwd_ff;
  cstp_action_e qry_rev_ff;
  cstp_tbl_t    active_tbl_ff;
  logic         track_en_ff;
  logic         have_prev_ff;
  cstp_pos_t    prev_pos_ff;
  logic [2:0]   irq_stat_ff;
  logic [2:0]   irq_mask_ff;
  logic [31:0]  rdata_ff;

  logic         exec_rise;
  cstp_cmd_s    nxt_cmd;
  cstp_entry_s  sel_entry;
  logic         pnt_ok;
  logic [15:0]  nxt_code;
  logic [7:0]   nxt_state;
  logic         any_cross;
  logic         fin_ok;
  logic         fin_err;
  logic         stat_rd;

  // ************************************************************
  // Command capture
  // ************************************************************
  // Rising execute only
  assign exec_rise = reg_wr && is_addr(reg_addr, `CSTP_CMD_OFS)
                     && reg_wdata[`CSTP_CMD_EXEC_BIT] && !exec_ff && (fsm_ff == FSM_IDLE);

  always_comb
  begin
    nxt_cmd.is_edit = reg_wdata[`CSTP_CMD_OP_BIT];
    nxt_cmd.kind    = reg_wdata[`CSTP_CMD_KIND_LSB +: 2];
    nxt_cmd.tbl     = reg_wdata[`CSTP_CMD_TBL_LSB +: 5];
    nxt_cmd.pnt     = reg_wdata[`CSTP_CMD_PNT_LSB +: 8];
    nxt_cmd.fwd     = cstp_action_e'(reg_wdata[`CSTP_CMD_FWD_LSB +: 2]);
    nxt_cmd.rev     = cstp_action_e'(reg_wdata[`CSTP_CMD_REV_LSB +: 2]);
    nxt_cmd.pos     = edit_pos_ff;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_reg_ff  <= `CSTP_CMD_RST;
      exec_ff     <= 1'b0;
      edit_pos_ff <= 32'h0000_0000;
    end
    else if (reg_wr)
    begin
      if (is_addr(reg_addr, `CSTP_CMD_OFS))
      begin
        cmd_reg_ff <= reg_wdata;
        exec_ff    <= reg_wdata[`CSTP_CMD_EXEC_BIT];
      end
      if (is_addr(reg_addr, `CSTP_EDIT_POS_OFS))
        edit_pos_ff <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cmd_ff <= '0;
    else if (exec_rise)
      cmd_ff <= nxt_cmd;
  end

  // ************************************************************
  // Command sequencing
  // ************************************************************
  assign sel_entry = table_ff[cmd_ff.tbl][cmd_ff.pnt[2:0]];
  assign pnt_ok    = cmd_ff.pnt < 8'(PNT_NUM);

  always_comb
  begin
    nxt_code = `CSTP_FAULT_NONE;
    if (!pnt_ok)
      nxt_code = `CSTP_FAULT_PNT_RNG;
    else if (!cmd_ff.is_edit)
      nxt_code = sel_entry.used ? `CSTP_FAULT_NONE : `CSTP_FAULT_EMPTY;
    else
      unique case (cmd_ff.kind)
        EDIT_WRITE:  nxt_code = `CSTP_FAULT_NONE;
        EDIT_ADD:    nxt_code = sel_entry.used ? `CSTP_FAULT_EXISTS : `CSTP_FAULT_NONE;
        EDIT_DELETE: nxt_code = sel_entry.used ? `CSTP_FAULT_NONE : `CSTP_FAULT_EMPTY;
        default:     nxt_code = `CSTP_FAULT_KIND;
      endcase
  end

  assign fin_ok  = (fsm_ff == FSM_RUN) && (nxt_code == `CSTP_FAULT_NONE);
  assign fin_err = (fsm_ff == FSM_RUN) && (nxt_code != `CSTP_FAULT_NONE);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      fsm_ff <= FSM_IDLE;
    else
      unique case (fsm_ff)
        FSM_IDLE: fsm_ff <= exec_rise ? FSM_RUN : FSM_IDLE;
        FSM_RUN:  fsm_ff <= FSM_IDLE;
      endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      busy_ff <= 1'b0;
    else
      busy_ff <= exec_rise;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done_ff  <= 1'b0;
      valid_ff <= 1'b0;
      error_ff <= 1'b0;
      code_ff  <= `CSTP_FAULT_NONE;
    end
    else if (exec_rise)
    begin
      done_ff  <= 1'b0;
      valid_ff <= 1'b0;
      error_ff <= 1'b0;
      code_ff  <= `CSTP_FAULT_NONE;
    end
    else if (fsm_ff == FSM_RUN)
    begin
      done_ff  <= fin_ok && cmd_ff.is_edit;
      valid_ff <= fin_ok && !cmd_ff.is_edit;
      error_ff <= fin_err;
      code_ff  <= nxt_code;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      qry_pos_ff <= 32'h0000_0000;
      qry_fwd_ff <= ACT_HOLD;
      qry_rev_ff <= ACT_HOLD;
    end
    else if (fin_ok && !cmd_ff.is_edit)
    begin
      qry_pos_ff <= sel_entry.pos;
      qry_fwd_ff <= sel_entry.fwd;
      qry_rev_ff <= sel_entry.rev;
    end
  end

  // ************************************************************
  // Point table and crossing tracking
  // ************************************************************
  // Write, add, delete
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      for (int t = 0; t < TBL_NUM; t++)
        for (int p = 0; p < PNT_NUM; p++)
          table_ff[t][p] <= '0;
    else if (fin_ok && cmd_ff.is_edit)
      if (cmd_ff.kind == EDIT_DELETE)
        table_ff[cmd_ff.tbl][cmd_ff.pnt[2:0]] <= '0;
      else
        table_ff[cmd_ff.tbl][cmd_ff.pnt[2:0]] <= {1'b1, cmd_ff.pos, cmd_ff.fwd, cmd_ff.rev};
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_tbl_ff <= 5'h00;
      track_en_ff   <= 1'b0;
    end
    else if (reg_wr && is_addr(reg_addr, `CSTP_SPINDLE_OFS))
    begin
      active_tbl_ff <= reg_wdata[4:0];
      track_en_ff   <= reg_wdata[8];
    end
  end

  // A fresh start after enable or table change avoids a bogus crossing from stale samples
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      have_prev_ff <= 1'b0;
      prev_pos_ff  <= 32'h0000_0000;
    end
    else if (reg_wr && is_addr(reg_addr, `CSTP_SPINDLE_OFS))
      have_prev_ff <= 1'b0;
    else if (spindle_stb && track_en_ff)
    begin
      have_prev_ff <= 1'b1;
      prev_pos_ff  <= spindle_pos;
    end
  end

  // Signed positions; forward means prev < point <= new
  always_comb
  begin
    cstp_entry_s e;
    logic        fwd_x;
    logic        rev_x;
    e         = '0;
    fwd_x     = 1'b0;
    rev_x     = 1'b0;
    nxt_state = state_ff[active_tbl_ff];
    any_cross = 1'b0;
    for (int p = 0; p < PNT_NUM; p++)
    begin
      e     = table_ff[active_tbl_ff][p];
      fwd_x = e.used && ($signed(prev_pos_ff) < $signed(e.pos)) && ($signed(spindle_pos) >= $signed(e.pos));
      rev_x = e.used && ($signed(prev_pos_ff) >= $signed(e.pos)) && ($signed(spindle_pos) < $signed(e.pos));
      if (fwd_x)
        nxt_state[p] = apply_action(e.fwd, state_ff[active_tbl_ff][p]);
      if (rev_x)
        nxt_state[p] = apply_action(e.rev, state_ff[active_tbl_ff][p]);
      any_cross = any_cross | fwd_x | rev_x;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      for (int t = 0; t < TBL_NUM; t++)
        state_ff[t] <= 8'h00;
    else
    begin
      if (spindle_stb && track_en_ff && have_prev_ff)
        state_ff[active_tbl_ff] <= nxt_state;
      if (fin_ok && cmd_ff.is_edit && cmd_ff.kind == EDIT_DELETE)
        state_ff[cmd_ff.tbl][cmd_ff.pnt[2:0]] <= 1'b0;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  assign stat_rd = reg_rd && is_addr(reg_addr, `CSTP_IRQ_STAT_OFS);

  // Set wins over the read clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat_ff <= 3'h0;
    else
      irq_stat_ff <= (stat_rd ? 3'h0 : irq_stat_ff)
                     | {spindle_stb && track_en_ff && have_prev_ff && any_cross, fin_err, fin_ok};
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_ff <= `CSTP_IRQ_MASK_RST;
    else if (reg_wr && is_addr(reg_addr, `CSTP_IRQ_MASK_OFS))
      irq_mask_ff <= reg_wdata[2:0];
  end

  // ************************************************************
  // Register read
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_ff <= 32'h0000_0000;
    else if (reg_rd)
      unique case (reg_addr)
        `CSTP_CMD_OFS:       rdata_ff <= cmd_reg_ff;
        `CSTP_EDIT_POS_OFS:  rdata_ff <= edit_pos_ff;
        `CSTP_STATUS_OFS:    rdata_ff <= {code_ff, 12'h000, error_ff, valid_ff, done_ff, busy_ff};
        `CSTP_QRY_POS_OFS:   rdata_ff <= qry_pos_ff;
        `CSTP_QRY_ACT_OFS:   rdata_ff <= {28'h0000000, qry_rev_ff, qry_fwd_ff};
        `CSTP_SPINDLE_OFS:   rdata_ff <= {23'h000000, track_en_ff, 3'h0, active_tbl_ff};
        `CSTP_PSTATE_OFS:    rdata_ff <= {24'h000000, state_ff[active_tbl_ff]};
        `CSTP_IRQ_STAT_OFS:  rdata_ff <= {29'h00000000, irq_stat_ff};
        `CSTP_IRQ_MASK_OFS:  rdata_ff <= {29'h00000000, irq_mask_ff};
        default:             rdata_ff <= 32'h0000_0000;
      endcase
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata   = rdata_ff;
  assign cmd_busy    = busy_ff;
  assign cmd_done    = done_ff;
  assign cmd_valid   = valid_ff;
  assign cmd_error   = error_ff;
  assign fault_code  = code_ff;
  assign point_state = state_ff[active_tbl_ff];
  assign irq         = |(irq_stat_ff & irq_mask_ff);

endmodule : cstp_point_table

`default_nettype wire

/* cstp_regs.svh */
// Register offsets, field positions, reset values and fault codes of the switch point table
`ifndef CSTP_REGS_SVH
`define CSTP_REGS_SVH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define CSTP_CMD_OFS        8'h00
`define CSTP_EDIT_POS_OFS   8'h04
`define CSTP_STATUS_OFS     8'h08
`define CSTP_QRY_POS_OFS    8'h0c
`define CSTP_QRY_ACT_OFS    8'h10
`define CSTP_SPINDLE_OFS    8'h14
`define CSTP_PSTATE_OFS     8'h18
`define CSTP_IRQ_STAT_OFS   8'h1c
`define CSTP_IRQ_MASK_OFS   8'h20

// ************************************************************
// Command register fields
// ************************************************************
`define CSTP_CMD_EXEC_BIT   0
`define CSTP_CMD_OP_BIT     1
`define CSTP_CMD_KIND_LSB   2
`define CSTP_CMD_TBL_LSB    8
`define CSTP_CMD_PNT_LSB    16
`define CSTP_CMD_FWD_LSB    24
`define CSTP_CMD_REV_LSB    26

// ************************************************************
// Status and interrupt fields
// ************************************************************
`define CSTP_ST_BUSY_BIT    0
`define CSTP_ST_DONE_BIT    1
`define CSTP_ST_VALID_BIT   2
`define CSTP_ST_ERR_BIT     3
`define CSTP_ST_CODE_LSB    16
`define CSTP_IRQ_DONE_BIT   0
`define CSTP_IRQ_ERR_BIT    1
`define CSTP_IRQ_CROSS_BIT  2

// ************************************************************
// Reset values and fault codes
// ************************************************************
`define CSTP_CMD_RST        32'h0000_0000
`define CSTP_IRQ_MASK_RST   3'h0
`define CSTP_FAULT_NONE     16'h0000
`define CSTP_FAULT_PNT_RNG  16'h0001
`define CSTP_FAULT_EMPTY    16'h0002
`define CSTP_FAULT_EXISTS   16'h0003
`define CSTP_FAULT_KIND     16'h0004

`endif

/* cstp_pkg.sv */
// Types shared by the cam switch point table
package cstp_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int TBL_NUM = 32;
  localparam int PNT_NUM = 8;

  typedef logic [4:0]  cstp_tbl_t;
  typedef logic [2:0]  cstp_pnt_t;
  typedef logic [31:0] cstp_pos_t;

  // ************************************************************
  // Enumerations
  // ************************************************************
  typedef enum logic [1:0] {
    ACT_HOLD   = 2'b00,
    ACT_SET    = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_TOGGLE = 2'b11
  } cstp_action_e;

  typedef enum logic [1:0] {
    EDIT_WRITE  = 2'b00,
    EDIT_ADD    = 2'b01,
    EDIT_DELETE = 2'b10
  } cstp_kind_e;

  typedef enum logic [1:0] {
    FSM_IDLE = 2'b00,
    FSM_RUN  = 2'b01
  } cstp_fsm_e;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic         is_edit;
    logic [1:0]   kind;
    cstp_tbl_t    tbl;
    logic [7:0]   pnt;
    cstp_action_e fwd;
    cstp_action_e rev;
    cstp_pos_t    pos;
  } cstp_cmd_s;

  typedef struct packed {
    logic         used;
    cstp_pos_t    pos;
    cstp_action_e fwd;
    cstp_action_e rev;
  } cstp_entry_s;

endpackage : cstp_pkg

/* cstp_point_table_checker.sv */
// Concurrent checks on the ports of the switch point table
`timescale 1ns/1ns
`default_nettype none
`include "cstp_regs.svh"

module cstp_point_table_checker
  import cstp_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Spindle samples
  input wire logic [31:0] spindle_pos,
  input wire logic        spindle_stb,
  // Status and states
  input wire logic        cmd_busy,
  input wire logic        cmd_done,
  input wire logic        cmd_valid,
  input wire logic        cmd_error,
  input wire logic [15:0] fault_code,
  input wire logic [7:0]  point_state,
  input wire logic        irq
);
  // ************************************************************
  // Helper logic
  // ************************************************************
  logic cmd_wr;
  logic start;
  logic exec_ff;
  logic start_ff;

  assign cmd_wr = reg_wr && reg_addr == `CSTP_CMD_OFS;
  assign start  = cmd_wr && reg_wdata[0] && !exec_ff && !cmd_busy;

  // Stored execute bit, so that only a rise counts as a start
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      exec_ff <= 1'b0;
    else if (cmd_wr)
      exec_ff <= reg_wdata[0];

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      start_ff <= 1'b0;
    else
      start_ff <= start;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_start;
    start;
  endsequence

  sequence s_finish;
    !cmd_busy && (cmd_done || cmd_valid || cmd_error);
  endsequence

  a_cmd_flow: assert property (s_start |=> cmd_busy ##1 s_finish)
    else $error("command did not run busy then finish");
  a_busy_cause: assert property (cmd_busy |-> start_ff)
    else $error("busy without a rising execute");
  a_busy_short: assert property (cmd_busy |=> !cmd_busy)
    else $error("busy longer than one cycle");
  a_flags_exclusive: assert property ($onehot0({cmd_busy, cmd_done, cmd_valid, cmd_error}))
    else $error("status flags not exclusive");
  a_start_clears: assert property (s_start |=> !cmd_done && !cmd_valid && !cmd_error)
    else $error("start did not clear results");
  a_result_stands: assert property ((cmd_done || cmd_valid || cmd_error) && !start
    |=> $stable({cmd_done, cmd_valid, cmd_error, fault_code}))
    else $error("result changed without a start");
  a_code_error: assert property (cmd_error == (fault_code != 16'h0))
    else $error("fault code and error disagree");
  a_state_cause: assert property ($changed(point_state)
    |-> $past(spindle_stb) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("point state changed without a cause");
  a_unmapped_zero: assert property (reg_rd && reg_addr > `CSTP_IRQ_MASK_OFS |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (reg_wr && reg_addr == `CSTP_IRQ_MASK_OFS && reg_wdata[2:0] == 3'h0
    |=> !irq)
    else $error("interrupt high with all masked");
endmodule : cstp_point_table_checker

bind cstp_point_table cstp_point_table_checker cstp_point_table_checker_i (
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spindle_pos(spindle_pos), .spindle_stb(spindle_stb),
  .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_valid(cmd_valid), .cmd_error(cmd_error),
  .fault_code(fault_code), .point_state(point_state), .irq(irq)
);

`default_nettype wire

/* cstp_spindle_model.sv */
// Spindle motion source feeding position samples to the table
`timescale 1ns/1ns
`default_nettype none

module cstp_spindle_model
  import cstp_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Motion request
  input  wire logic        go,
  input  wire logic [31:0] tgt,
  input  wire logic [3:0]  gap,
  output logic             arrived,
  // Samples toward the table
  output logic      [31:0] spindle_pos,
  output logic             spindle_stb
);
  logic [31:0] cur_ff;
  logic [31:0] nxt_cur;
  logic [3:0]  wait_ff;
  logic        run_ff;

  assign arrived = !run_ff;

  // Steps of 60, so points are passed over rather than only landed on
  always_comb
  begin
    if ($signed(tgt - cur_ff) > 60)
      nxt_cur = cur_ff + 32'h3c;
    else if ($signed(cur_ff - tgt) > 60)
      nxt_cur = cur_ff - 32'h3c;
    else
      nxt_cur = tgt;
  end

  // Outside a strobe the position wanders, so a stale sample is never seen as valid
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_ff <= 32'h0;
      wait_ff <= 4'h0;
      run_ff <= 1'b0;
      spindle_stb <= 1'b0;
      spindle_pos <= 32'h0;
    end
    else if (go)
    begin
      run_ff <= 1'b1;
      wait_ff <= 4'h0;
      spindle_stb <= 1'b0;
      spindle_pos <= ~spindle_pos;
    end
    else if (run_ff && wait_ff == 4'h0)
    begin
      spindle_stb <= 1'b1;
      spindle_pos <= cur_ff;
      cur_ff <= nxt_cur;
      run_ff <= cur_ff != tgt;
      wait_ff <= gap;
    end
    else
    begin
      spindle_stb <= 1'b0;
      spindle_pos <= ~spindle_pos;
      if (wait_ff != 4'h0)
        wait_ff <= wait_ff - 4'h1;
    end
  end
endmodule : cstp_spindle_model

`default_nettype wire

/* cstp_point_table_tb.sv */
// Self-checking bench for the switch point table
`timescale 1ns/1ns
`default_nettype none
`include "cstp_regs.svh"

module cstp_point_table_tb
  import cstp_pkg::*;
;
  logic        mclk, rst_n, reg_wr, reg_rd, spindle_stb, go, arrived;
  logic        cmd_busy, cmd_done, cmd_valid, cmd_error, irq;
  logic [7:0]  reg_addr, point_state;
  logic [31:0] reg_wdata, reg_rdata, spindle_pos, tgt;
  logic [15:0] fault_code;
  logic [3:0]  gap;
  int          n_fail, num_checks, cyc;

  cstp_point_table cstp_point_table_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .spindle_pos(spindle_pos), .spindle_stb(spindle_stb), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
    .cmd_valid(cmd_valid), .cmd_error(cmd_error), .fault_code(fault_code),
    .point_state(point_state), .irq(irq));
  cstp_spindle_model cstp_spindle_model_i (.mclk(mclk), .rst_n(rst_n), .go(go), .tgt(tgt),
    .gap(gap), .arrived(arrived), .spindle_pos(spindle_pos), .spindle_stb(spindle_stb));

  always #5 mclk = ~mclk;

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, msg);
  endtask : rchk

  // One command, then the execute bit is dropped so the next one rises again
  task automatic cmd(input logic op, input logic [1:0] kd, input logic [4:0] t, input logic [7:0] p,
                     input logic [1:0] fw, input logic [1:0] rv, input logic [31:0] ps,
                     input logic [15:0] code);
    logic [31:0] w;
    w = {4'h0, rv, fw, p, 3'h0, t, 4'h0, kd, op, 1'b1};
    wr(`CSTP_EDIT_POS_OFS, ps);
    wr(`CSTP_CMD_OFS, w);
    #1 chk({31'h0, cmd_busy}, 32'h1, "busy");
    wr(`CSTP_CMD_OFS, {w[31:1], 1'b0});
    #1 chk({29'h0, cmd_done, cmd_valid, cmd_error}, (code != 16'h0) ? 32'h1 : (op ? 32'h4 : 32'h2), "flags");
    chk({16'h0, fault_code}, {16'h0, code}, "fault code");
  endtask : cmd

  task automatic qchk(input logic [4:0] t, input logic [7:0] p, input logic [31:0] ps,
                      input logic [1:0] fw, input logic [1:0] rv);
    cmd(1'b0, 2'h0, t, p, 2'h0, 2'h0, 32'h0, 16'h0);
    rchk(`CSTP_QRY_POS_OFS, ps, "query pos");
    rchk(`CSTP_QRY_ACT_OFS, {28'h0, rv, fw}, "query act");
  endtask : qchk

  task automatic move(input logic [31:0] t, input logic [3:0] g, input logic [7:0] exp);
    int i;
    @(posedge mclk);
    tgt <= t;
    gap <= g;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    i = 0;
    #1;
    while (!arrived && i < 300)
    begin
      @(posedge mclk);
      #1;
      i++;
    end
    repeat (2) @(posedge mclk);
    #1 chk({24'h0, point_state}, {24'h0, exp}, "point state");
  endtask : move

  // ************************************************************
  // Sequence
  // ************************************************************
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      $display("[FAIL] %0t run too long", $time);
      close_out();
    end
  end

  initial
  begin
    {mclk, rst_n, reg_wr, reg_rd, go, reg_addr, reg_wdata, tgt, gap} = '0;
    {n_fail, num_checks, cyc} = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(`CSTP_STATUS_OFS, 32'h0, "status reset");
    rchk(`CSTP_IRQ_MASK_OFS, 32'h0, "mask reset");
    rchk(`CSTP_PSTATE_OFS, 32'h0, "state reset");
    rchk(8'h24, 32'h0, "unmapped");
    $display("test reset done");
    cmd(1'b0, 2'h0, 5'd5, 8'd0, 2'h0, 2'h0, 32'h0, `CSTP_FAULT_EMPTY);
    cmd(1'b1, EDIT_WRITE, 5'd5, 8'd8, 2'h1, 2'h1, 32'h0, `CSTP_FAULT_PNT_RNG);
    cmd(1'b1, 2'h3, 5'd5, 8'd0, 2'h0, 2'h0, 32'h0, `CSTP_FAULT_KIND);
    cmd(1'b1, EDIT_DELETE, 5'd5, 8'd0, 2'h0, 2'h0, 32'h0, `CSTP_FAULT_EMPTY);
    $display("test faults done");
    for (int i = 0; i < 4; i++)
      cmd(1'b1, EDIT_ADD, 5'd5, 8'(i), 2'(i), 2'(3 - i), 32'(100 * (i + 1)), 16'h0);
    cmd(1'b1, EDIT_ADD, 5'd5, 8'd0, 2'h0, 2'h0, 32'h0, `CSTP_FAULT_EXISTS);
    cmd(1'b1, EDIT_WRITE, 5'd5, 8'd4, 2'h0, 2'h0, 32'd450, 16'h0);
    cmd(1'b1, EDIT_WRITE, 5'd31, 8'd7, 2'h3, 2'h1, 32'hffff_fffb, 16'h0);
    for (int i = 0; i < 4; i++)
      qchk(5'd5, 8'(i), 32'(100 * (i + 1)), 2'(i), 2'(3 - i));
    qchk(5'd5, 8'd4, 32'd450, 2'h0, 2'h0);
    qchk(5'd31, 8'd7, 32'hffff_fffb, 2'h3, 2'h1);
    wr(`CSTP_CMD_OFS, 32'h0000_0501);
    wr(`CSTP_CMD_OFS, 32'h0009_0501);
    #1 chk({31'h0, cmd_busy}, 32'h0, "no rise no start");
    repeat (2) @(posedge mclk);
    #1 chk({29'h0, cmd_done, cmd_valid, cmd_error}, 32'h2, "result kept");
    wr(`CSTP_CMD_OFS, 32'h0);
    $display("test edit and query done");
    wr(`CSTP_SPINDLE_OFS, 32'h0000_0105);
    rchk(`CSTP_SPINDLE_OFS, 32'h0000_0105, "spindle reg");
    move(32'd0, 4'h0, 8'h00);
    move(32'd500, 4'h0, 8'h0a);
    move(32'd0, 4'h3, 8'h0d);
    move(32'd500, 4'h1, 8'h03);
    rchk(`CSTP_PSTATE_OFS, 32'h03, "state reg");
    wr(`CSTP_SPINDLE_OFS, 32'h0000_0005);
    move(32'd0, 4'h0, 8'h03);
    cmd(1'b1, EDIT_DELETE, 5'd5, 8'd1, 2'h0, 2'h0, 32'h0, 16'h0);
    chk({24'h0, point_state}, 32'h01, "state after delete");
    cmd(1'b0, 2'h0, 5'd5, 8'd1, 2'h0, 2'h0, 32'h0, `CSTP_FAULT_EMPTY);
    $display("test crossing done");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(`CSTP_IRQ_MASK_OFS, 32'h4);
    #1 chk({31'h0, irq}, 32'h1, "irq crossing");
    rchk(`CSTP_IRQ_STAT_OFS, 32'h7, "irq status");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    cmd(1'b0, 2'h0, 5'd5, 8'd1, 2'h0, 2'h0, 32'h0, `CSTP_FAULT_EMPTY);
    chk({31'h0, irq}, 32'h0, "error masked");
    wr(`CSTP_IRQ_MASK_OFS, 32'h2);
    #1 chk({31'h0, irq}, 32'h1, "irq error");
    wr(`CSTP_IRQ_MASK_OFS, 32'h0);
    #1 chk({31'h0, irq}, 32'h0, "irq all masked");
    rchk(`CSTP_IRQ_STAT_OFS, 32'h2, "irq status error");
    $display("test interrupt done");
    close_out();
  end
endmodule : cstp_point_table_tb

`default_nettype wire
